// ### common/adc_seq_defs.svh
// timing counts, command encodings and reset values of the conversion sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// system clock and fastest allowed sequencer clock, in hertz
`define SYS_CLK_HZ 25000000
`define SEQ_CLK_MAX_HZ 2600000
// sequencer tick divisor, rounded up so the tick never exceeds the fastest rate
`define SEQ_DIV ((`SYS_CLK_HZ + `SEQ_CLK_MAX_HZ - 1) / `SEQ_CLK_MAX_HZ)

// data bus and result widths
`define BUS_W 16
`define RESULT_W 13
`define CMD_W 6

// sequencer cycle counts
`define SEQ_CNT_W 7
`define CONV_CYCLES 7'h1B
`define CAL_CYCLES 7'h69
`define SAMPLE_FIRST 7'h03
`define SAMPLE_LAST 7'h0A
`define FIRST_CYCLE 7'h01

// command word patterns on the six low data lines: (word & mask) == value
`define CMD_CONV_MASK 6'h31
`define CMD_CONV_VALUE 6'h20
`define CMD_CAL_MASK 6'h2F
`define CMD_CAL_VALUE 6'h00

// reset values
`define RST_DONE_N 1'b1
`define RST_RESULT 13'h0000
`define RST_DATA_OUT 16'h0000

`endif

// ### common/adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CAL = 3'b100
  } seq_state_type;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_CONV = 2'b01,
    CMD_CAL = 2'b10
  } cmd_type;

endpackage

// ### verilog/seq_clock_divider.sv
// divider that makes the one-cycle sequencer tick from the system clock
`include "adc_seq_defs.svh"

module seq_clock_divider #(
  parameter int DIV = `SEQ_DIV
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic restart,
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_q;
  logic tick_q;
  wire last_w;

  assign last_w = (cnt_q == CW'(DIV - 1));
  assign tick = tick_q;

  // restart realigns the phase so a freshly latched command gets a full first cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (restart) begin
        cnt_q <= '0;
      end else if (run) begin
        if (last_w) begin
          cnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule

// ### verilog/adc_host_conversion_sequencer.sv
// host bus and conversion sequencer of a self-calibrating 13-bit converter
//
// How it works
// - calibration never starts at power-up or reset, only when the host writes the calibrate word.
// - a conversion runs whether or not a calibration has completed; calibration only adds accuracy.
// - a conversion word on the six low data lines is latched and started when select or write returns high.
// - the analog input is sampled during sequencer cycles three through ten of a conversion.
// - a conversion ends at the end of its twenty-seventh cycle with the result then readable.
// - the done flag goes low when a conversion completes.
// - a new command is accepted at once after completion, with no idle cycles.
// - a command latched while a sequence runs abandons it and restarts from cycle one.
// - while select and read are both low the result is driven onto the data bus.
// - the result is right justified two's complement with the sign copied into the upper bus bits.
// - the sign bit is low for a positive and high for a negative input difference.
// - the data outputs are released when read rises at the end of the access.
// - calibration occupies the sequencer for 105 cycles and conversion for 27, in any order.
// - the done flag returns high on a falling select-and-read or select-and-write strobe.
// - the device inserts one wait state at the start of a read access, with the data already driven.
// - stored calibration is invalid once the sequencer clock stops, until a new calibrate.
`include "adc_seq_defs.svh"

module adc_host_conversion_sequencer #(
  parameter int BUS_W = `BUS_W,
  parameter int RES_W = `RESULT_W,
  parameter int DIV = `SEQ_DIV
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [BUS_W-1:0] DATA_IN,
  output logic [BUS_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic DONE_N,
  output logic WAIT_INSERT,
  input wire logic CLK_HALT,
  input wire logic [RES_W-1:0] ADC_CODE,
  output logic SAMPLE_EN,
  output logic CAL_VALID,
  output adc_seq_pkg::seq_state_type SEQ_STATE
);
  import adc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic cmd_type decode_cmd(input logic [`CMD_W-1:0] word);
    cmd_type c;
    c = CMD_NONE;
    if ((word & `CMD_CONV_MASK) == `CMD_CONV_VALUE) begin
      c = CMD_CONV;
    end else if ((word & `CMD_CAL_MASK) == `CMD_CAL_VALUE) begin
      c = CMD_CAL;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // host strobes

  logic wr_act_q;
  logic rd_act_q;
  logic [`CMD_W-1:0] cmd_word_q;
  wire wr_act;
  wire rd_act;
  wire wr_rise;
  wire wr_fall;
  wire rd_fall;
  wire cmd_type latched_cmd;
  wire cmd_go;
  wire conv_go;
  wire cal_go;

  assign wr_act = ~CS_N & ~WR_N;
  assign rd_act = ~CS_N & ~RD_N;
  assign wr_rise = wr_act_q & ~wr_act;
  assign wr_fall = wr_act & ~wr_act_q;
  assign rd_fall = rd_act & ~rd_act_q;
  assign latched_cmd = decode_cmd(cmd_word_q);
  assign conv_go = wr_rise & (latched_cmd == CMD_CONV);
  assign cal_go = wr_rise & (latched_cmd == CMD_CAL);
  assign cmd_go = conv_go | cal_go;

  // the word is held while the write strobe is low and used when it rises
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      cmd_word_q <= '0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        cmd_word_q <= DATA_IN[`CMD_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  seq_state_type state_q;
  seq_state_type state_d;
  logic [`SEQ_CNT_W-1:0] cnt_q;
  logic [`SEQ_CNT_W-1:0] cnt_d;
  wire tick;
  wire busy;
  wire at_conv_end;
  wire at_cal_end;
  wire conv_end;
  wire cal_end;

  // the tick stops with the sequencer clock, and restarts its phase on each latch
  seq_clock_divider #(
    .DIV(DIV)
  ) u_div (
    .clk(CLK_SYS),
    .srst(SRST),
    .run(~CLK_HALT),
    .restart(cmd_go),
    .tick(tick)
  );

  assign busy = (state_q != ST_IDLE);
  assign at_conv_end = (state_q == ST_CONV) & (cnt_q == `CONV_CYCLES);
  assign at_cal_end = (state_q == ST_CAL) & (cnt_q == `CAL_CYCLES);
  // a command in the last cycle abandons the sequence, so no completion is reported
  assign conv_end = tick & at_conv_end & ~cmd_go;
  assign cal_end = tick & at_cal_end & ~cmd_go;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (conv_go) begin
      state_d = ST_CONV;
      cnt_d = `FIRST_CYCLE;
    end else if (cal_go) begin
      state_d = ST_CAL;
      cnt_d = `FIRST_CYCLE;
    end else if (tick & busy) begin
      if (at_conv_end | at_cal_end) begin
        state_d = ST_IDLE;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_d)
        ST_IDLE: state_q <= ST_IDLE;
        ST_CONV: state_q <= ST_CONV;
        ST_CAL: state_q <= ST_CAL;
        default: state_q <= ST_IDLE;
      endcase
      cnt_q <= cnt_d;
    end
  end

  assign SEQ_STATE = state_q;

  ////////////////////////////////////////////////////////////////////////////////
  // sampling, calibration state and result

  logic sample_q;
  logic cal_valid_q;
  logic [RES_W-1:0] result_q;
  wire sample_d;
  wire sign_bit;
  wire [BUS_W-1:0] bus_word;

  assign sample_d = (state_d == ST_CONV) & (cnt_d >= `SAMPLE_FIRST) & (cnt_d <= `SAMPLE_LAST);
  assign sign_bit = result_q[RES_W-1];
  assign bus_word = {{(BUS_W - RES_W){sign_bit}}, result_q};

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sample_q <= 1'b0;
      cal_valid_q <= 1'b0;
      result_q <= `RST_RESULT;
    end else begin
      sample_q <= sample_d;
      if (CLK_HALT | cal_go) begin
        cal_valid_q <= 1'b0;
      end else if (cal_end) begin
        cal_valid_q <= 1'b1;
      end
      if (conv_end) begin
        result_q <= ADC_CODE;
      end
    end
  end

  assign SAMPLE_EN = sample_q;
  assign CAL_VALID = cal_valid_q;

  ////////////////////////////////////////////////////////////////////////////////
  // done flag, read port and wait insertion

  logic done_n_q;
  logic oe_q;
  logic wait_q;
  logic [BUS_W-1:0] dout_q;
  logic done_n_d;

  // completion wins over a clearing strobe in the same cycle
  always_comb begin
    done_n_d = done_n_q;
    if (rd_fall | wr_fall | cmd_go) begin
      done_n_d = 1'b1;
    end
    if (conv_end) begin
      done_n_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      done_n_q <= `RST_DONE_N;
      oe_q <= 1'b0;
      wait_q <= 1'b0;
      dout_q <= `RST_DATA_OUT;
    end else begin
      done_n_q <= done_n_d;
      oe_q <= rd_act;
      wait_q <= rd_act & ~oe_q;
      dout_q <= bus_word;
    end
  end

  assign DONE_N = done_n_q;
  assign DATA_OE = oe_q;
  assign WAIT_INSERT = wait_q;
  assign DATA_OUT = dout_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [`SEQ_CNT_W-1:0] ticks_q;

  // ticks seen since the latest command latch
  always_ff @(posedge CLK_SYS) begin
    if (SRST | cmd_go) begin
      ticks_q <= '0;
    end else if (tick & busy) begin
      ticks_q <= ticks_q + 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_conv_latch;
    conv_go;
  endsequence

  sequence s_conv_first_cycle;
    (state_q == ST_CONV) && (cnt_q == `FIRST_CYCLE);
  endsequence

  a_no_reset_cal: assert property ($past(SRST) |-> !CAL_VALID)
    else $error("calibration valid right after reset");

  a_cal_only_by_cmd: assert property ($rose(CAL_VALID) |-> $past(state_q) == ST_CAL && ticks_q == `CAL_CYCLES)
    else $error("calibration valid without a full calibrate sequence");

  a_conv_restart: assert property (s_conv_latch |=> s_conv_first_cycle)
    else $error("conversion command did not restart the sequence");

  a_conv_accept: assert property ((conv_go && !busy) |=> state_q == ST_CONV)
    else $error("command after completion not accepted");

  a_conv_no_cal: assert property ((conv_go && !CAL_VALID) |=> busy ##0 SEQ_STATE == ST_CONV)
    else $error("conversion refused without calibration");

  a_sample_window: assert property (SAMPLE_EN |-> state_q == ST_CONV && cnt_q >= 7'h03 && cnt_q <= 7'h0A)
    else $error("sampling outside cycles three to ten");

  a_conv_length: assert property ($fell(DONE_N) |-> ticks_q == 7'h1B && SEQ_STATE == ST_IDLE)
    else $error("conversion did not end after 27 cycles");

  a_done_on_end: assert property (conv_end |=> !DONE_N)
    else $error("done flag not low at completion");

  a_done_held_busy: assert property (busy |-> DONE_N)
    else $error("done flag low while a sequence runs");

  a_done_clear: assert property ((rd_fall && !conv_end) |=> DONE_N)
    else $error("done flag not cleared by read strobe");

  a_bus_drive: assert property (rd_act |=> DATA_OE && DATA_OUT[RES_W-1:0] == $past(result_q))
    else $error("result not driven during read");

  a_bus_release: assert property ($rose(RD_N) |=> !DATA_OE)
    else $error("data bus not released after read");

  a_sign_extend: assert property (DATA_OE |-> DATA_OUT[BUS_W-1:RES_W] == {(BUS_W - RES_W){DATA_OUT[RES_W-1]}})
    else $error("upper bus bits do not copy the sign");

  a_sign_source: assert property (conv_end |-> ##2 DATA_OUT[RES_W-1] == $past(ADC_CODE[RES_W-1], 2))
    else $error("sign bit not taken from the result");

  a_wait_read: assert property (rd_fall |=> (WAIT_INSERT && DATA_OE) ##1 !WAIT_INSERT)
    else $error("no wait state at start of read");

  a_cal_lost: assert property (CLK_HALT |=> !CAL_VALID)
    else $error("calibration kept while clock stopped");

  a_cmd_latch: assert property ((wr_rise && latched_cmd != CMD_NONE) |=> busy && cnt_q == 7'h01)
    else $error("command not started on strobe rise");

endmodule

// ### verif/host_bus_model.sv
// host microprocessor model for the parallel command and result bus
module host_bus_model (
  input wire logic clk,
  input wire logic wait_insert,
  input wire logic data_oe,
  input wire logic [15:0] data_out,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 16'h5A5A;
  end

  ////////////////////////////////////////
  // command word held over two edges, then strobes released before the data moves
  task automatic write_word(input logic [5:0] word);
    @(negedge clk);
    data_in = {~data_in[15:6], word};
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    @(negedge clk);
    data_in = ~data_in;
  endtask

  // read held until the wait request drops with the bus driven
  task automatic read_word(output logic [15:0] val, output bit ok, output int waits);
    ok = 1'b0;
    val = 16'h0000;
    waits = 0;
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      if (wait_insert === 1'b1) waits++;
      if (wait_insert === 1'b0 && data_oe === 1'b1) begin
        val = data_out;
        ok = 1'b1;
      end
    end
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
endmodule

// ### verif/test_adc_host_conversion_sequencer.sv
// self-checking bench: cycle-count model of the sequencer against the design
`include "adc_seq_defs.svh"

module test_adc_host_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  localparam int DIV = 2;
  localparam int CONV_T = int'(`CONV_CYCLES) * DIV;
  localparam int CAL_T = int'(`CAL_CYCLES) * DIV;
  localparam int SAMP_T = (int'(`SAMPLE_LAST) - int'(`SAMPLE_FIRST) + 1) * DIV;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_halt = 1'b0;
  logic [12:0] adc_code = 13'h0000;
  logic cs_n, wr_n, rd_n, data_oe, done_n, wait_insert, sample_en, cal_valid;
  logic [15:0] data_in, data_out, rd_val;
  seq_state_type seq_state;
  logic [5:0] words[4] = '{6'h20, 6'h2E, 6'h22, 6'h2C};
  logic [15:0] exp_q[$];
  bit ok;
  int err_count = 0;
  int checked = 0;
  int n, samp, hi, waits;

  always #20 clk_sys = ~clk_sys;

  adc_host_conversion_sequencer #(.BUS_W(16), .RES_W(13), .DIV(DIV)) dut (
    .CLK_SYS(clk_sys), .SRST(srst), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .DATA_IN(data_in),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .DONE_N(done_n), .WAIT_INSERT(wait_insert),
    .CLK_HALT(clk_halt), .ADC_CODE(adc_code), .SAMPLE_EN(sample_en), .CAL_VALID(cal_valid),
    .SEQ_STATE(seq_state));

  host_bus_model host (.clk(clk_sys), .wait_insert(wait_insert), .data_oe(data_oe),
    .data_out(data_out), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in));

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // counts cycles until done falls or calibration becomes valid
  task automatic wait_done(input bit cal);
    n = 0;
    samp = 0;
    hi = 1;
    while ((cal ? cal_valid !== 1'b1 : done_n !== 1'b0) && n < 2000) begin
      @(negedge clk_sys);
      n++;
      if (sample_en === 1'b1) samp++;
      if (cal && done_n !== 1'b1) hi = 0;
    end
    if (n >= 2000) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic run_conv(input logic [5:0] word, input bit abort, input bit sign);
    logic [12:0] code;
    code = {sign, 12'($urandom)};
    adc_code = code;
    if (abort) begin
      host.write_word(6'h20);
      repeat (int'(`SAMPLE_LAST) * DIV) @(negedge clk_sys);
      check(done_n, 1'b1, "done during abort");
    end
    host.write_word(word);
    @(negedge clk_sys);
    check(seq_state, ST_CONV, "conv state");
    check(done_n, 1'b1, "done held");
    wait_done(1'b0);
    adc_code = ~code;
    check(32'(n >= CONV_T - 2 && n <= CONV_T + 2), 1, "conv length");
    check(samp, SAMP_T, "sample window");
    exp_q.push_back({{3{code[12]}}, code});
  endtask

  task automatic read_check;
    host.read_word(rd_val, ok, waits);
    if (!ok) begin
      err_count++;
      complete_run();
    end
    check(waits, 1, "wait states");
    check(rd_val, exp_q[$], "result");
    check(rd_val[15], exp_q[$][12], "sign");
    check(done_n, 1'b1, "done after read");
    @(negedge clk_sys);
    check(data_oe, 1'b0, "bus released");
    exp_q.delete();
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(55));
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    repeat (20) @(negedge clk_sys);
    check(seq_state, ST_IDLE, "idle");
    check(cal_valid, 1'b0, "no cal at start");
    check(done_n, 1'b1, "done at start");
    check(data_oe, 1'b0, "bus idle at start");
    check(wait_insert, 1'b0, "no wait at start");
    $display("test reset finished");
    // uncalibrated conversions; the second skips its read so the third starts at once and aborts
    for (int i = 0; i < 4; i++) begin
      run_conv(words[i], i == 2, i[0]);
      if (i != 1) read_check();
      $display("test conversion %0d finished", i);
    end
    run_conv(6'h20, 1'b0, 1'b1);
    host.write_word(6'h3F);
    @(negedge clk_sys);
    check(seq_state, ST_IDLE, "ignored word");
    check(done_n, 1'b1, "done after write");
    read_check();
    $display("test ignored word finished");
    host.write_word(6'h10);
    @(negedge clk_sys);
    check(seq_state, ST_CAL, "cal state");
    wait_done(1'b1);
    check(32'(n >= CAL_T - 2 && n <= CAL_T + 2), 1, "cal length");
    check(hi, 1, "done during cal");
    run_conv(6'h20, 1'b0, 1'b0);
    read_check();
    clk_halt = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(cal_valid, 1'b0, "cal lost on halt");
    clk_halt = 1'b0;
    $display("test calibration finished");
    complete_run();
  end
endmodule
